// *** inc/adcsp_pkg.sv ***
package adcsp_pkg;
	// Control byte length, result width, conversion length
	localparam int CTRL_BITS   = 8;
	localparam int RES_BITS    = 12;
	localparam int TRACK_BIT   = 5;
	localparam int HOLD_BIT    = 8;
	localparam int EXT_CONV_CLKS = 15;
	localparam logic [3:0] CNT_W0 = 4'h0;
	// Control byte field positions (bit index in byte)
	localparam int CB_PD_LSB   = 0;
	localparam int CB_INTCLK   = 1;
	// Internal conversion time
	localparam int INT_CONV_NS = 10000;
	localparam int CLK_NS      = 5;
	localparam int INT_CONV_CYC = INT_CONV_NS / CLK_NS;
	// Three-level shutdown encoding
	typedef enum logic [1:0] {ADCSP_PD_LOW, ADCSP_PD_HIGH, ADCSP_PD_FLOAT}
		adcsp_pdsel_e;
endpackage

// *** core/adcsp_fifo.sv ***
`timescale 1ns/1ps
module adcsp_fifo
#(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
)
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_r;
	logic [AW:0]      rp_r;
	logic [AW:0]      cnt_r;
	wire  [AW:0]      cnt_nxt;
	wire              empty;
	wire              wr;
	wire              rd;
	wire              consume;
	assign empty = (wp_r == rp_r);
	assign wr = in_valid && in_ready;
	// Read data sits in a register, so refill when empty or consumed
	assign rd = !empty && (!out_valid || out_ready);
	assign consume = out_valid && out_ready;
	// Occupancy counts the output register too, else one extra word fits
	assign cnt_nxt = (wr && !consume) ? cnt_r + 1'b1
		: (!wr && consume) ? cnt_r - 1'b1 : cnt_r;
	always_ff @(posedge clk)
	begin
		if (wr)
			mem[wp_r[AW-1:0]] <= in_data;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
			out_data <= '0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			in_ready <= (cnt_nxt != (AW+1)'(DEPTH));
			if (wr)
				wp_r <= wp_r + 1'b1;
			if (rd)
			begin
				rp_r <= rp_r + 1'b1;
				out_data <= mem[rp_r[AW-1:0]];
				out_valid <= 1'b1;
			end
			else if (out_ready)
				out_valid <= 1'b0;
		end
	end
endmodule

// *** core/adcsp_port.sv ***
`timescale 1ns/1ps
module adcsp_port
	import adcsp_pkg::*;
#(
	parameter int INT_CYC = INT_CONV_CYC,
	parameter int DEPTH   = 16
)
(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                sclk,
	input  wire logic                cs_n,
	input  wire logic                din,
	input  wire logic                pd_low_in,
	input  wire logic                pd_float_in,
	input  wire logic [RES_BITS-1:0] sample_data,
	input  wire logic                sample_valid,
	output logic                     sample_ready,
	output logic                     dout_o,
	output logic                     dout_oe_n,
	output logic                     strobe_o,
	output logic                     strobe_oe_n,
	output logic                     power_down,
	output logic                     comp_internal,
	output logic                     track,
	output logic                     busy
);
	typedef enum {ST_IDLE, ST_CTRL, ST_CONV, ST_SHIFT} adcsp_state_e;
	adcsp_state_e     st_r;
	logic [2:0]       sclk_s_r;
	logic [1:0]       cs_s_r;
	logic [1:0]       din_s_r;
	logic [1:0]       pdl_s_r;
	logic [1:0]       pdf_s_r;
	logic [CTRL_BITS-1:0] ctrl_r;
	logic [3:0]       bit_r;
	logic [RES_BITS:0] res_r;
	logic [$clog2(INT_CYC+1)-1:0] tmr_r;
	logic             ext_r;
	logic [RES_BITS-1:0] fd;
	wire              fv;
	wire              fr;
	wire              rise;
	wire              fall;
	wire              cs_act;
	wire              pd_now;
	wire              int_done;
	wire              conv_fall;
	// Two stages before use; third stage only feeds the edge compare
	assign rise   = sclk_s_r[1] && !sclk_s_r[2];
	assign fall   = !sclk_s_r[1] && sclk_s_r[2];
	assign cs_act = !cs_s_r[1];
	assign pd_now = pdl_s_r[1];
	assign int_done = (tmr_r == '0);
	assign conv_fall = fall && cs_act && st_r == ST_CONV && ext_r;
	assign fr = (st_r == ST_CONV)
		&& (ext_r ? (bit_r == CNT_W0 + 4'h1) && conv_fall : int_done);

	adcsp_fifo #(.WIDTH(RES_BITS), .DEPTH(DEPTH)) u_fifo
	(
		.clk       (clk),
		.rst       (rst),
		.in_data   (sample_data),
		.in_valid  (sample_valid),
		.in_ready  (sample_ready),
		.out_data  (fd),
		.out_valid (fv),
		.out_ready (fr)
	);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sclk_s_r <= '0;
			cs_s_r <= 2'h3;
			din_s_r <= '0;
			pdl_s_r <= '0;
			pdf_s_r <= '0;
		end
		else
		begin
			sclk_s_r <= {sclk_s_r[1:0], sclk};
			cs_s_r <= {cs_s_r[0], cs_n};
			din_s_r <= {din_s_r[0], din};
			pdl_s_r <= {pdl_s_r[0], pd_low_in};
			pdf_s_r <= {pdf_s_r[0], pd_float_in};
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			power_down <= 1'b0;
			comp_internal <= 1'b1;
		end
		else
		begin
			power_down <= pd_now;
			comp_internal <= !pdf_s_r[1];
		end
	end

	// Control byte intake and conversion sequencing
	always_ff @(posedge clk)
	begin
		if (rst || pd_now)
		begin
			st_r <= ST_IDLE;
			ctrl_r <= '0;
			bit_r <= CNT_W0;
			ext_r <= 1'b0;
			track <= 1'b0;
			busy <= 1'b0;
			tmr_r <= '0;
			res_r <= '0;
		end
		else
		begin
			unique case (st_r)
			ST_IDLE:
				if (rise && cs_act && din_s_r[1])
				begin
					st_r <= ST_CTRL;
					ctrl_r <= {{(CTRL_BITS-1){1'b0}}, 1'b1};
					bit_r <= 4'h1;
				end
			ST_CTRL:
			begin
				if (rise && cs_act)
				begin
					ctrl_r <= {ctrl_r[CTRL_BITS-2:0], din_s_r[1]};
					bit_r <= bit_r + 4'h1;
				end
				if (fall && bit_r == 4'(TRACK_BIT))
					track <= 1'b1;
				if (fall && bit_r == 4'(HOLD_BIT))
				begin
					track <= 1'b0;
					st_r <= ST_CONV;
					busy <= 1'b1;
					ext_r <= !ctrl_r[CB_INTCLK];
					tmr_r <= ($clog2(INT_CYC+1))'(INT_CYC);
					bit_r <= 4'h2;
				end
			end
			ST_CONV:
				if (ext_r)
				begin
					if (conv_fall)
						bit_r <= bit_r - 4'h1;
					if (fr)
					begin
						res_r <= {1'b0, fv ? fd : '0};
						st_r <= ST_SHIFT;
						bit_r <= 4'(RES_BITS);
					end
				end
				else if (int_done)
				begin
					res_r <= {1'b0, fv ? fd : '0};
					busy <= 1'b0;
					st_r <= ST_SHIFT;
					bit_r <= 4'(RES_BITS);
				end
				else
					tmr_r <= tmr_r - 1'b1;
			ST_SHIFT:
				if (fall && cs_act)
				begin
					res_r <= {res_r[RES_BITS-1:0], 1'b0};
					bit_r <= bit_r - 4'h1;
					if (bit_r == CNT_W0)
					begin
						st_r <= ST_IDLE;
						busy <= 1'b0;
					end
				end
			endcase
		end
	end

	// Pin outputs registered; enable is low while driving
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dout_o <= 1'b0;
			dout_oe_n <= 1'b1;
			strobe_o <= 1'b1;
			strobe_oe_n <= 1'b1;
		end
		else
		begin
			dout_oe_n <= !cs_act;
			if (fall)
				dout_o <= (st_r == ST_SHIFT) ? res_r[RES_BITS] : 1'b0;
			if (st_r == ST_CONV && !ext_r)
			begin
				strobe_oe_n <= 1'b0;
				strobe_o <= 1'b0;
			end
			else if (ext_r && st_r == ST_CONV)
			begin
				strobe_oe_n <= !cs_act;
				if (fall)
					strobe_o <= (bit_r == 4'h2);
			end
			else
			begin
				strobe_o <= ext_r ? 1'b0 : 1'b1;
				strobe_oe_n <= ext_r ? !cs_act : 1'b0;
			end
		end
	end
endmodule

// *** dv/adcsp_props.sv ***
`timescale 1ns/1ps
module adcsp_chk
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic pd_low_in,
	input wire logic pd_float_in,
	input wire logic dout_o,
	input wire logic dout_oe_n,
	input wire logic strobe_o,
	input wire logic strobe_oe_n,
	input wire logic power_down,
	input wire logic comp_internal,
	input wire logic track,
	input wire logic busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Synchroniser delay puts the sampled fall two to five cycles back
	sequence s_fell;
		!$past(sclk, 2) && $past(sclk, 5);
	endsequence
	sequence s_hi8;
		strobe_o[*8];
	endsequence
	oe_off_a: assert property (cs_n[*5] |-> dout_oe_n)
		else $error("dout driven");
	dout_edge_a: assert property
		(!dout_oe_n && $changed(dout_o) |-> s_fell)
		else $error("dout off edge");
	track_edge_a: assert property ($changed(track) |-> s_fell)
		else $error("track off edge");
	cs_idle_a: assert property (cs_n[*6] |-> !$rose(busy))
		else $error("busy unselected");
	pd_on_a: assert property (pd_low_in[*4] |-> power_down)
		else $error("no power down");
	comp_int_a: assert property
		((!pd_low_in && !pd_float_in)[*4] |-> comp_internal)
		else $error("comp not int");
	comp_ext_a: assert property
		((!pd_low_in && pd_float_in)[*4] |-> !comp_internal)
		else $error("comp not ext");
	strobe_hold_a: assert property
		($rose(strobe_o) && !strobe_oe_n |-> s_hi8)
		else $error("strobe short");
endmodule
bind adcsp_port adcsp_chk u_chk (.clk(clk), .rst(rst), .sclk(sclk),
	.cs_n(cs_n), .pd_low_in(pd_low_in), .pd_float_in(pd_float_in),
	.dout_o(dout_o), .dout_oe_n(dout_oe_n), .strobe_o(strobe_o),
	.strobe_oe_n(strobe_oe_n), .power_down(power_down),
	.comp_internal(comp_internal), .track(track), .busy(busy));

// *** dv/adcsp_host.sv ***
`timescale 1ns/1ps
module adcsp_host
(
	input  wire logic clk,
	input  wire logic dpin,
	input  wire logic spin,
	output logic      sclk,
	output logic      cs_n,
	output logic      din
);
	logic act = 1'b0;
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end
	// Idle data toggles so a stale bit can never pass as a real one
	always @(posedge clk)
		if (!act)
			din <= ~din;
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bt(input logic b, inout logic [15:0] rx);
		din <= b;
		wt(8);
		sclk <= 1'b1;
		rx = {rx[14:0], dpin};
		wt(8);
		sclk <= 1'b0;
	endtask
	task automatic frame(input logic [7:0] cb, input int z, input bit ic,
		output logic [15:0] rx, output logic sl);
		int i;
		rx = 16'h0000;
		sl = 1'b0;
		act = 1'b1;
		wt(1);
		cs_n <= 1'b0;
		wt(4);
		for (i = 0; i < z + 8; i++)
			bt(i < z ? 1'b0 : cb[7 - (i - z)], rx);
		if (ic)
			wt(8);
		sl = spin;
		for (i = 0; ic && spin !== 1'b1 && i < 400; i++)
			wt(1);
		for (i = 0; i < 16; i++)
			bt(1'b0, rx);
		wt(4);
		cs_n <= 1'b1;
		act = 1'b0;
	endtask
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import adcsp_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pd_low_in = 1'b0;
	logic pd_float_in = 1'b0;
	logic [RES_BITS-1:0] sample_data = 12'h000;
	logic sample_valid = 1'b0;
	logic sclk, cs_n, din, sample_ready, dout_o, dout_oe_n, strobe_o;
	logic strobe_oe_n, power_down, comp_internal, track, busy, sl;
	wire dpin = dout_oe_n ? 1'bz : dout_o;
	wire spin = strobe_oe_n ? 1'bz : strobe_o;
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	int i;
	logic [15:0] r = 16'h003c;
	logic [15:0] rx;
	logic [7:0] cb;
	logic [RES_BITS-1:0] ex;
	logic [RES_BITS-1:0] q[$];
	always #2.5 clk = ~clk;
	adcsp_port #(.INT_CYC(20)) dut (.clk(clk), .rst(rst), .sclk(sclk),
		.cs_n(cs_n), .din(din), .pd_low_in(pd_low_in),
		.pd_float_in(pd_float_in), .sample_data(sample_data),
		.sample_valid(sample_valid), .sample_ready(sample_ready),
		.dout_o(dout_o), .dout_oe_n(dout_oe_n), .strobe_o(strobe_o),
		.strobe_oe_n(strobe_oe_n), .power_down(power_down),
		.comp_internal(comp_internal), .track(track), .busy(busy));
	adcsp_host host (.clk(clk), .dpin(dpin), .spin(spin), .sclk(sclk),
		.cs_n(cs_n), .din(din));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// External mode: strobe period, load fall and pad bit lead the MSB;
	// internal mode: the pad bit follows the wait for the strobe edge
	function automatic logic [15:0] exp_frame(input logic [RES_BITS-1:0] d,
		input logic ic);
		return ic ? {2'h0, d, 2'h0} : {4'h0, d};
	endfunction
	task automatic cmp(input string nm, input logic [15:0] e, s);
		compares++;
		if (s !== e)
		begin
			err_count++;
			$display("mismatch %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic summarize;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			summarize();
		end
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		cmp("comp", 16'h1, comp_internal);
		pd_float_in <= 1'b1;
		repeat (8) @(posedge clk);
		cmp("comp", 16'h0, comp_internal);
		pd_low_in <= 1'b1;
		repeat (8) @(posedge clk);
		cmp("pdown", 16'h1, power_down);
		pd_low_in <= 1'b0;
		pd_float_in <= 1'b0;
		sample_data <= r[11:0];
		sample_valid <= 1'b1;
		for (i = 0; i < 40; i++)
		begin
			@(posedge clk);
			if (sample_ready === 1'b1)
			begin
				q.push_back(sample_data);
				r = lfsr(r);
				sample_data <= r[11:0];
			end
		end
		sample_valid <= 1'b0;
		cmp("depth", 16'd16, q.size());
		// One extra frame reads the empty buffer
		for (i = 0; i <= 16; i++)
		begin
			r = lfsr(r);
			cb = {1'b1, r[6:2], r[7], 1'b1};
			ex = q.size() ? q.pop_front() : 12'h000;
			host.frame(cb, r[1:0], r[7], rx, sl);
			cmp("result", exp_frame(ex, r[7]), rx);
			if (r[7])
				cmp("strobe low", 16'h0, sl);
			repeat (6) @(posedge clk);
			cmp("dout oe", 16'h1, dout_oe_n);
			if (!r[7])
				cmp("strobe oe", 16'h1, strobe_oe_n);
		end
		summarize();
	end
endmodule
